// ### hdl/fiap_dev.sv
/*
 Sequencer end: special registers, 128-word write buffer, unlock gate,
 erase/program/read sequencing toward the flash array.
 Assumes a flash array that takes one beat per fl_valid/fl_ready handshake.
*/
`timescale 1ns/100ps
module fiap_dev #(
   parameter int UNLOCK_CYCLES = fiap_pkg::UNLOCK_CYCLES
) (
   fiap_if.dev                      bus,
   output logic                     fl_valid,
   output fiap_pkg::fiap_flop_t     fl_op,
   output logic [15:0]              fl_addr,
   output logic [fiap_pkg::WORD_W-1:0] fl_wdata,
   input  wire logic                fl_ready,
   input  wire logic [fiap_pkg::WORD_W-1:0] fl_rdata
);
   import fiap_pkg::*;

   typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_ERASE = 4'b0010,
                             ST_PROG = 4'b0100, ST_READ = 4'b1000} fiap_st_t;

   fiap_st_t             state;
   logic                 unlock_status;
   logic [2:0]           operation_select;
   logic                 unlock_trigger;
   logic                 program_go;
   logic                 read_allow;
   logic                 read_go;
   logic                 buffer_flush;
   logic                 aux4;
   logic                 aux7;
   logic [7:0]           flash_addr_low;
   logic [7:0]           flash_addr_high;
   logic [7:0]           prog_data_low;
   logic [7:0]           prog_data_high;
   logic [7:0]           key_q [KEY_N];
   logic [WORD_W-1:0]    wbuf [PAGE_WORDS];
   logic [IDX_W-1:0]     wb_idx;
   logic [IDX_W-1:0]     beat;
   logic [31:0]          utimer;
   logic                 ctrl_wr;
   logic                 aux_wr;
   logic                 key_ok;
   logic                 start_erase;
   logic                 start_prog;
   logic                 start_read;
   logic                 start_trig;
   logic                 op_done;
   logic [2:0]           wr_mode;
   logic [PAGE_W-1:0]    page;
   logic [KEY_N-1:0]     key_hit;

   assign ctrl_wr = bus.sfr_wr && (bus.sfr_addr == REG_CTRL);
   assign aux_wr  = bus.sfr_wr && (bus.sfr_addr == REG_AUX);
   assign wr_mode = bus.sfr_wdata[B_MODE_LO +: 3];
   assign page    = {flash_addr_high, flash_addr_low[7]};
   assign start_erase = ctrl_wr && bus.sfr_wdata[B_PGO] && (wr_mode == MODE_ERASE)
                        && unlock_status && (state == ST_IDLE);
   assign start_prog  = ctrl_wr && bus.sfr_wdata[B_PGO] && (wr_mode == MODE_WRITE)
                        && unlock_status && (state == ST_IDLE);
   assign start_read  = ctrl_wr && bus.sfr_wdata[B_RGO] && (wr_mode == MODE_READ)
                        && read_allow && (state == ST_IDLE);
   assign start_trig  = ctrl_wr && bus.sfr_wdata[B_TRIG] && (wr_mode == MODE_UNLOCK)
                        && !unlock_trigger;
   assign op_done     = (state != ST_IDLE) && fl_ready
                        && ((state != ST_PROG) || (beat == IDX_W'(PAGE_WORDS - 1)));

   genvar gk;
   generate
      for (gk = 0; gk < KEY_N; gk++) begin : g_key
         assign key_hit[gk] = (key_q[gk] == UNLOCK_KEY[gk]);
      end
   endgenerate
   assign key_ok = &key_hit;

   // Stall the core while any flash operation is pending
   assign bus.cpu_stall = program_go || read_go;
   assign fl_valid = (state != ST_IDLE);

   always_comb begin
      unique case (state)
         ST_ERASE: fl_op = FIAP_FL_ERASE;
         ST_PROG:  fl_op = FIAP_FL_PROG;
         default:  fl_op = FIAP_FL_READ;
      endcase
   end

   // Control register fields
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         operation_select <= MODE_WRITE;
         read_allow       <= 1'b0;
         program_go       <= 1'b0;
         read_go          <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            operation_select <= wr_mode;
            read_allow       <= bus.sfr_wdata[B_RALLOW];
         end
         if (start_erase || start_prog) begin
            program_go <= 1'b1;
         end else if (op_done && (state != ST_READ)) begin
            program_go <= 1'b0;
         end
         if (start_read) begin
            read_go <= 1'b1;
         end else if (op_done && (state == ST_READ)) begin
            read_go <= 1'b0;
         end
      end
   end

   // Unlock timer, key capture and unlock status
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         unlock_trigger <= 1'b0;
         utimer         <= '0;
         unlock_status  <= 1'b0;
         for (int i = 0; i < KEY_N; i++) begin
            key_q[i] <= 8'h00;
         end
      end else begin
         if (start_trig) begin
            unlock_trigger <= 1'b1;
            utimer         <= 32'(UNLOCK_CYCLES - 1);
            for (int i = 0; i < KEY_N; i++) begin
               key_q[i] <= ~UNLOCK_KEY[i];
            end
         end else begin
            if (unlock_trigger) begin
               if (utimer == '0) begin
                  unlock_trigger <= 1'b0;
               end else begin
                  utimer <= utimer - 32'd1;
               end
            end
            for (int i = 0; i < KEY_N; i++) begin
               if (bus.sfr_wr && (bus.sfr_addr == REG_AW'(REG_KEY0 + i))) begin
                  key_q[i] <= bus.sfr_wdata;
               end
            end
         end
         if (unlock_trigger && key_ok) begin
            unlock_status <= 1'b1;
         end else if (ctrl_wr && !bus.sfr_wdata[B_UNLOCK]) begin
            unlock_status <= 1'b0;
         end
      end
   end

   // Address, data and aux registers
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         flash_addr_low  <= 8'h00;
         flash_addr_high <= 8'h00;
         prog_data_low   <= 8'h00;
         prog_data_high  <= 8'h00;
         buffer_flush    <= 1'b0;
         aux4            <= 1'b0;
         aux7            <= 1'b0;
      end else begin
         if (bus.sfr_wr && (bus.sfr_addr == REG_ADDR_LO)) begin
            flash_addr_low <= bus.sfr_wdata;
         end
         if (bus.sfr_wr && (bus.sfr_addr == REG_ADDR_HI)) begin
            flash_addr_high <= bus.sfr_wdata;
         end
         if (op_done && (state == ST_READ)) begin
            prog_data_low  <= fl_rdata[7:0];
            prog_data_high <= fl_rdata[15:8];
         end else begin
            if (bus.sfr_wr && (bus.sfr_addr == REG_DATA_LO)) begin
               prog_data_low <= bus.sfr_wdata;
            end
            if (bus.sfr_wr && (bus.sfr_addr == REG_DATA_HI)) begin
               prog_data_high <= bus.sfr_wdata;
            end
         end
         if (aux_wr) begin
            aux4 <= bus.sfr_wdata[B_AUX4];
            aux7 <= bus.sfr_wdata[B_AUX7];
         end
         if (aux_wr && bus.sfr_wdata[B_FLUSH]) begin
            buffer_flush <= 1'b1;
         end else begin
            buffer_flush <= 1'b0;
         end
      end
   end

   // Write buffer fill and flush
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         wb_idx <= '0;
         for (int i = 0; i < PAGE_WORDS; i++) begin
            wbuf[i] <= '0;
         end
      end else begin
         if (buffer_flush) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
               wbuf[i] <= '0;
            end
         end else if (bus.sfr_wr && (bus.sfr_addr == REG_DATA_HI)
                      && (operation_select == MODE_WRITE) && (state == ST_IDLE)) begin
            wbuf[wb_idx] <= {bus.sfr_wdata, prog_data_low};
         end
         if (bus.sfr_wr && (bus.sfr_addr == REG_ADDR_LO)) begin
            wb_idx <= bus.sfr_wdata[IDX_W-1:0];
         end else if (bus.sfr_wr && (bus.sfr_addr == REG_DATA_HI)
                      && (operation_select == MODE_WRITE) && (state == ST_IDLE)
                      && (wb_idx != IDX_W'(PAGE_WORDS - 1))) begin
            wb_idx <= wb_idx + IDX_W'(1);
         end
      end
   end

   // Flash sequencing
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         state    <= ST_IDLE;
         beat     <= '0;
         fl_addr  <= 16'h0000;
         fl_wdata <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               beat <= '0;
               if (start_erase) begin
                  state   <= ST_ERASE;
                  fl_addr <= {page, IDX_W'(0)};
               end else if (start_prog) begin
                  state    <= ST_PROG;
                  fl_addr  <= {page, IDX_W'(0)};
                  fl_wdata <= wbuf[0];
               end else if (start_read) begin
                  state   <= ST_READ;
                  fl_addr <= {flash_addr_high, flash_addr_low};
               end
            end
            ST_PROG: begin
               if (fl_ready) begin
                  if (beat == IDX_W'(PAGE_WORDS - 1)) begin
                     state <= ST_IDLE;
                  end else begin
                     beat     <= beat + IDX_W'(1);
                     fl_addr  <= {page, beat + IDX_W'(1)};
                     fl_wdata <= wbuf[beat + IDX_W'(1)];
                  end
               end
            end
            ST_ERASE, ST_READ: begin
               if (fl_ready) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Registered read port
   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         bus.sfr_rdata <= 8'h00;
      end else if (bus.sfr_rd) begin
         if (bus.sfr_addr == REG_CTRL) begin
            bus.sfr_rdata <= {unlock_status, operation_select, unlock_trigger,
                              program_go, read_allow, read_go};
         end else if (bus.sfr_addr == REG_AUX) begin
            bus.sfr_rdata <= {aux7, 2'b00, aux4, 3'b000, buffer_flush};
         end else if (bus.sfr_addr == REG_ADDR_LO) begin
            bus.sfr_rdata <= flash_addr_low;
         end else if (bus.sfr_addr == REG_ADDR_HI) begin
            bus.sfr_rdata <= flash_addr_high;
         end else if (bus.sfr_addr == REG_DATA_LO) begin
            bus.sfr_rdata <= prog_data_low;
         end else if (bus.sfr_addr == REG_DATA_HI) begin
            bus.sfr_rdata <= prog_data_high;
         end else begin
            bus.sfr_rdata <= 8'h00;
         end
      end
   end
endmodule : fiap_dev

// ### hdl/fiap_host.sv
/*
 Processor end: turns user commands into ordered special-register accesses,
 waits through stalls and busy bits, and returns a result.
 Assumes the sequencer end answers reads one cycle after sfr_rd.
*/
`timescale 1ns/100ps
module fiap_host (
   fiap_if.host                 bus,
   input  wire logic            cmd_valid,
   input  fiap_pkg::fiap_cmd_t  cmd_op,
   input  wire logic [15:0]     cmd_addr,
   input  wire logic [15:0]     cmd_data,
   output logic                 cmd_ready,
   output logic                 rsp_valid,
   output logic [15:0]          rsp_data
);
   import fiap_pkg::*;

   typedef enum logic [4:0] {H_IDLE = 5'b00001, H_WR = 5'b00010, H_POLL = 5'b00100,
                             H_CHK = 5'b01000, H_GET = 5'b10000} fiap_hst_t;

   fiap_hst_t    state;
   fiap_cmd_t    op;
   logic [15:0]  a_q;
   logic [15:0]  d_q;
   logic [2:0]   step;
   logic [12:0]  act;
   logic [3:0]   poll_reg;
   logic [7:0]   poll_mask;

   // Returns {last, register, value} for one access of a command
   function automatic logic [12:0] fiap_step(input fiap_cmd_t o, input logic [2:0] s,
                                             input logic [15:0] a, input logic [15:0] d);
      logic [12:0] r;
      r = {1'b1, REG_CTRL, CTRL_LOCK};
      unique case (o)
         FIAP_UNLOCK:  r = (s == 3'd0) ? {1'b0, REG_CTRL, CTRL_UNLOCK_GO}
                           : {s == 3'(KEY_N), REG_AW'(REG_KEY0 + s - 3'd1),
                              UNLOCK_KEY[s - 3'd1]};
         FIAP_SETADDR: r = (s == 3'd0) ? {1'b0, REG_ADDR_LO, a[7:0]}
                                       : {1'b1, REG_ADDR_HI, a[15:8]};
         FIAP_ERASE:   r = {1'b1, REG_CTRL, CTRL_ERASE_GO};
         FIAP_LOAD: begin
            if (s == 3'd0) r = {1'b0, REG_CTRL, CTRL_WRITE_MODE};
            else if (s == 3'd1) r = {1'b0, REG_DATA_LO, d[7:0]};
            else r = {1'b1, REG_DATA_HI, d[15:8]};
         end
         FIAP_PROGRAM: r = {1'b1, REG_CTRL, CTRL_PROG_GO};
         FIAP_READ: begin
            if (s == 3'd0) r = {1'b0, REG_ADDR_LO, a[7:0]};
            else if (s == 3'd1) r = {1'b0, REG_ADDR_HI, a[15:8]};
            else if (s == 3'd2) r = {1'b0, REG_CTRL, CTRL_READ_EN};
            else r = {1'b1, REG_CTRL, CTRL_READ_GO};
         end
         FIAP_FLUSH:   r = {1'b1, REG_AUX, AUX_FLUSH};
         FIAP_LOCK:    r = {1'b1, REG_CTRL, CTRL_LOCK};
      endcase
      return r;
   endfunction : fiap_step

   assign act       = fiap_step(op, step, a_q, d_q);
   assign cmd_ready = (state == H_IDLE);
   assign poll_reg  = (op == FIAP_FLUSH) ? REG_AUX : REG_CTRL;
   assign poll_mask = (op == FIAP_FLUSH) ? AUX_BUSY_MASK : CTRL_BUSY_MASK;

   always_ff @(posedge bus.mclk or negedge bus.nrst) begin
      if (!bus.nrst) begin
         state         <= H_IDLE;
         op            <= FIAP_LOCK;
         a_q           <= 16'h0000;
         d_q           <= 16'h0000;
         step          <= 3'd0;
         bus.sfr_addr  <= REG_CTRL;
         bus.sfr_wdata <= 8'h00;
         bus.sfr_wr    <= 1'b0;
         bus.sfr_rd    <= 1'b0;
         rsp_valid     <= 1'b0;
         rsp_data      <= 16'h0000;
      end else begin
         bus.sfr_wr <= 1'b0;
         bus.sfr_rd <= 1'b0;
         rsp_valid  <= 1'b0;
         unique case (state)
            H_IDLE: begin
               if (cmd_valid) begin
                  op    <= cmd_op;
                  a_q   <= cmd_addr;
                  d_q   <= cmd_data;
                  step  <= 3'd0;
                  state <= H_WR;
               end
            end
            H_WR: begin
               if (!bus.cpu_stall) begin
                  bus.sfr_wr    <= 1'b1;
                  bus.sfr_addr  <= act[11:8];
                  bus.sfr_wdata <= act[7:0];
                  step          <= step + 3'd1;
                  if (act[12]) begin
                     state <= H_POLL;
                  end
               end
            end
            H_POLL: begin
               // Skip the cycle after a write, so a fresh go bit stalls first
               if (!bus.cpu_stall && !bus.sfr_wr) begin
                  bus.sfr_rd   <= 1'b1;
                  bus.sfr_addr <= poll_reg;
                  state        <= H_CHK;
               end
            end
            H_CHK: begin
               if (bus.sfr_rd) begin
                  state <= H_CHK;
               end else if ((bus.sfr_rdata & poll_mask) != 8'h00) begin
                  state <= H_POLL;
               end else if (op == FIAP_READ) begin
                  step  <= 3'd0;
                  state <= H_GET;
               end else begin
                  rsp_data  <= {8'h00, bus.sfr_rdata};
                  rsp_valid <= 1'b1;
                  state     <= H_IDLE;
               end
            end
            H_GET: begin
               step <= step + 3'd1;
               if (step == 3'd0) begin
                  bus.sfr_rd   <= 1'b1;
                  bus.sfr_addr <= REG_DATA_LO;
               end else if (step == 3'd1) begin
                  bus.sfr_rd   <= 1'b1;
                  bus.sfr_addr <= REG_DATA_HI;
               end else if (step == 3'd2) begin
                  rsp_data[7:0] <= bus.sfr_rdata;
               end else begin
                  rsp_data[15:8] <= bus.sfr_rdata;
                  rsp_valid      <= 1'b1;
                  state          <= H_IDLE;
               end
            end
         endcase
      end
   end
endmodule : fiap_host

// ### hdl/fiap_if.sv
/*
 Special-register port joining the processor end and the sequencer end.
 Assumes both ends share mclk and nrst.
*/
`timescale 1ns/100ps
interface fiap_if (input wire logic mclk, input wire logic nrst);
   import fiap_pkg::*;
   logic [REG_AW-1:0] sfr_addr;
   logic [7:0]        sfr_wdata;
   logic              sfr_wr;
   logic              sfr_rd;
   logic [7:0]        sfr_rdata;
   logic              cpu_stall;
   modport dev  (input mclk, nrst, sfr_addr, sfr_wdata, sfr_wr, sfr_rd,
                 output sfr_rdata, cpu_stall);
   modport host (input mclk, nrst, sfr_rdata, cpu_stall,
                 output sfr_addr, sfr_wdata, sfr_wr, sfr_rd);
endinterface : fiap_if

// ### hdl/fiap_pkg.sv
/*
 Shared constants for the flash in-application programming sequencer.
 Assumes an 8-bit special-register port between processor and sequencer.
*/
package fiap_pkg;
   localparam int             REG_AW      = 4;
   localparam int             WORD_W      = 16;
   localparam int             PAGE_WORDS  = 128;
   localparam int             IDX_W       = 7;
   localparam int             PAGE_W      = 9;
   localparam int             KEY_N       = 6;
   localparam logic [3:0]     REG_CTRL    = 4'h0;
   localparam logic [3:0]     REG_AUX     = 4'h1;
   localparam logic [3:0]     REG_ADDR_LO = 4'h2;
   localparam logic [3:0]     REG_ADDR_HI = 4'h3;
   localparam logic [3:0]     REG_DATA_LO = 4'h4;
   localparam logic [3:0]     REG_DATA_HI = 4'h5;
   localparam logic [3:0]     REG_KEY0    = 4'h6;
   localparam int             B_UNLOCK    = 7;
   localparam int             B_MODE_LO   = 4;
   localparam int             B_TRIG      = 3;
   localparam int             B_PGO       = 2;
   localparam int             B_RALLOW    = 1;
   localparam int             B_RGO       = 0;
   localparam int             B_FLUSH     = 0;
   localparam int             B_AUX4      = 4;
   localparam int             B_AUX7      = 7;
   localparam logic [2:0]     MODE_WRITE  = 3'b000;
   localparam logic [2:0]     MODE_ERASE  = 3'b001;
   localparam logic [2:0]     MODE_READ   = 3'b011;
   localparam logic [2:0]     MODE_UNLOCK = 3'b110;
   // Key order: low bytes 1..3 then high bytes 1..3
   localparam logic [7:0]     UNLOCK_KEY [KEY_N] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
   localparam int             UNLOCK_CYCLES = 1024;
   localparam logic [7:0]     CTRL_UNLOCK_GO = 8'hE8;
   localparam logic [7:0]     CTRL_ERASE_GO  = 8'h94;
   localparam logic [7:0]     CTRL_PROG_GO   = 8'h84;
   localparam logic [7:0]     CTRL_WRITE_MODE = 8'h80;
   localparam logic [7:0]     CTRL_READ_EN   = 8'hB2;
   localparam logic [7:0]     CTRL_READ_GO   = 8'hB3;
   localparam logic [7:0]     CTRL_LOCK      = 8'h00;
   localparam logic [7:0]     AUX_FLUSH      = 8'h01;
   localparam logic [7:0]     CTRL_BUSY_MASK = 8'h0D;
   localparam logic [7:0]     AUX_BUSY_MASK  = 8'h01;
   typedef enum logic [1:0] {FIAP_FL_ERASE = 2'h0, FIAP_FL_PROG = 2'h1,
                             FIAP_FL_READ = 2'h2} fiap_flop_t;
   typedef enum logic [2:0] {FIAP_UNLOCK = 3'h0, FIAP_SETADDR = 3'h1, FIAP_ERASE = 3'h2,
                             FIAP_LOAD = 3'h3, FIAP_PROGRAM = 3'h4, FIAP_READ = 3'h5,
                             FIAP_FLUSH = 3'h6, FIAP_LOCK = 3'h7} fiap_cmd_t;
endpackage : fiap_pkg

// ### tb/fiap_asserts.sv
/*
 Checker on the special-register port between processor and sequencer ends.
 Assumes it is instantiated beside fiap_if in the bench top.
*/
`timescale 1ns/100ps
module fiap_asserts (
   input wire logic                        mclk,
   input wire logic                        nrst,
   input wire logic [fiap_pkg::REG_AW-1:0] sfr_addr,
   input wire logic [7:0]                  sfr_wdata,
   input wire logic                        sfr_wr,
   input wire logic                        sfr_rd,
   input wire logic [7:0]                  sfr_rdata,
   input wire logic                        cpu_stall
);
   import fiap_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic allow_q;
   // Read allow as last written
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) allow_q <= 1'b0;
      else if (sfr_wr && sfr_addr == REG_CTRL) allow_q <= sfr_wdata[B_RALLOW];
   end
   property p_no_wr_stall; cpu_stall |-> !sfr_wr; endproperty
   a_no_wr_stall: assert property (p_no_wr_stall) else $error("write during stall");
   property p_no_rd_stall; cpu_stall |-> !sfr_rd; endproperty
   a_no_rd_stall: assert property (p_no_rd_stall) else $error("read during stall");
   property p_stall_cause; $rose(cpu_stall) |-> $past(sfr_wr && sfr_addr == REG_CTRL); endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without go");
   property p_stall_end; $rose(cpu_stall) |-> ##[1:600] !cpu_stall; endproperty
   a_stall_end: assert property (p_stall_end) else $error("stall too long");
   property p_lo_hi;
      sfr_wr && sfr_addr == REG_DATA_HI |-> $past(sfr_wr) && $past(sfr_addr) == REG_DATA_LO;
   endproperty
   a_lo_hi: assert property (p_lo_hi) else $error("high byte before low");
   property p_rgo;
      sfr_wr && sfr_addr == REG_CTRL && sfr_wdata[B_RGO] |-> allow_q && sfr_wdata[B_RALLOW];
   endproperty
   a_rgo: assert property (p_rgo) else $error("read go before allow");
   property p_rdata_hold; !$past(sfr_rd) |-> $stable(sfr_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_aux_zero; sfr_rd && sfr_addr == REG_AUX |=> sfr_rdata[6:1] == 6'h00; endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("aux bits set");
   property p_excl; !(sfr_wr && sfr_rd); endproperty
   a_excl: assert property (p_excl) else $error("read and write together");
   c_stall: cover property ($rose(cpu_stall));
   c_hi: cover property (sfr_wr && sfr_addr == REG_DATA_HI);
   c_unlock: cover property (sfr_wr && sfr_addr == REG_CTRL && sfr_wdata == CTRL_UNLOCK_GO);
endmodule : fiap_asserts

// ### tb/tb_flash_iap_write_read_sequencer.sv
/*
 Bench: both ends joined by fiap_if, host driven by commands, small flash model.
 Assumes the package constants and a 16-cycle unlock window.
*/
`timescale 1ns/100ps
module tb_flash_iap_write_read_sequencer;
   import fiap_pkg::*;
   logic        mclk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, fl_ready = 1'b0;
   logic        cmd_ready, rsp_valid, fl_valid;
   fiap_cmd_t   cmd_op = FIAP_LOCK;
   fiap_flop_t  fl_op;
   logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000;
   logic [15:0] rsp_data, fl_addr, fl_wdata, fl_rdata, rv;
   logic [15:0] mem [0:1023];
   logic [15:0] ta [3] = '{16'h017E, 16'h017F, 16'h0100};
   logic [15:0] te [3] = '{16'h1111, 16'h3333, 16'h0000};
   int          error_cnt = 0, n_checks = 0, cyc = 0;
   always #2 mclk = ~mclk;
   fiap_if bus (.mclk(mclk), .nrst(nrst));
   fiap_dev #(.UNLOCK_CYCLES(16)) i_fiap_dev (.bus(bus), .fl_valid(fl_valid), .fl_op(fl_op),
      .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ready(fl_ready), .fl_rdata(fl_rdata));
   fiap_host i_fiap_host (.bus(bus), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   fiap_asserts i_fiap_asserts (.mclk(mclk), .nrst(nrst), .sfr_addr(bus.sfr_addr),
      .sfr_wdata(bus.sfr_wdata), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd),
      .sfr_rdata(bus.sfr_rdata), .cpu_stall(bus.cpu_stall));
   assign fl_rdata = mem[fl_addr[9:0]];
   // Flash array: two cycles a beat
   always @(posedge mclk) begin
      fl_ready <= fl_valid && !fl_ready;
      if (fl_valid && fl_ready) begin
         if (fl_op == FIAP_FL_ERASE) begin
            for (int i = 0; i < 128; i++) mem[{fl_addr[9:7], 7'(i)}] <= 16'h0000;
         end else if (fl_op == FIAP_FL_PROG) begin
            mem[fl_addr[9:0]] <= fl_wdata;
         end
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cmd(input fiap_cmd_t op, input logic [15:0] a, input logic [15:0] d);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      do @(negedge mclk); while (cmd_ready !== 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      do @(negedge mclk); while (rsp_valid !== 1'b1);
      rv = rsp_data;
      @(posedge mclk);
   endtask : cmd
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 16'h5A00 ^ 16'(i);
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      cmd(FIAP_SETADDR, 16'h0100, 16'h0000);
      cmd(FIAP_ERASE, 16'h0100, 16'h0000);
      chk("sw unlock", {15'h0000, rv[B_UNLOCK]}, 16'h0000);
      cmd(FIAP_READ, 16'h0100, 16'h0000);
      chk("locked erase", rv, 16'h5B00);
      cmd(FIAP_UNLOCK, 16'h0000, 16'h0000);
      chk("unlock", {15'h0000, rv[B_UNLOCK]}, 16'h0001);
      cmd(FIAP_SETADDR, 16'h0100, 16'h0000);
      cmd(FIAP_ERASE, 16'h0100, 16'h0000);
      cmd(FIAP_READ, 16'h017F, 16'h0000);
      chk("page end erased", rv, 16'h0000);
      cmd(FIAP_READ, 16'h0180, 16'h0000);
      chk("next page kept", rv, 16'h5B80);
      cmd(FIAP_FLUSH, 16'h0000, 16'h0000);
      cmd(FIAP_SETADDR, 16'h017E, 16'h0000);
      cmd(FIAP_LOAD, 16'h0000, 16'h1111);
      cmd(FIAP_LOAD, 16'h0000, 16'h2222);
      cmd(FIAP_LOAD, 16'h0000, 16'h3333);
      cmd(FIAP_PROGRAM, 16'h0000, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         cmd(FIAP_READ, ta[i], 16'h0000);
         chk("page word", rv, te[i]);
      end
      cmd(FIAP_FLUSH, 16'h0000, 16'h0000);
      cmd(FIAP_SETADDR, 16'h0105, 16'h0000);
      cmd(FIAP_LOAD, 16'h0000, 16'h4444);
      cmd(FIAP_PROGRAM, 16'h0000, 16'h0000);
      cmd(FIAP_READ, 16'h0105, 16'h0000);
      chk("rewrite", rv, 16'h4444);
      cmd(FIAP_READ, 16'h017E, 16'h0000);
      chk("flushed word", rv, 16'h0000);
      cmd(FIAP_LOCK, 16'h0000, 16'h0000);
      cmd(FIAP_SETADDR, 16'h0105, 16'h0000);
      cmd(FIAP_ERASE, 16'h0000, 16'h0000);
      cmd(FIAP_READ, 16'h0105, 16'h0000);
      chk("relocked erase", rv, 16'h4444);
      end_sim();
   end
endmodule : tb_flash_iap_write_read_sequencer
